// >>> verilog/etc_pkg.sv
// Contract
// R1 - line zero-crossing pulses (120 or 100 pps) are divided down to a 2 Hz tick
// R2 - strap selects first division by 5 for 50 Hz or 6 for 60 Hz mains
// R3 - first divider also yields a 60 pps tick used as the fastest rate; the code takes it from a toggle on every second line pulse instead
// R4 - toggle halves 2 Hz into 1 pps; modulo-60 counter then gives 1 ppm
// R5 - timing chain is cascaded modulo 60, 10 and 10 counters (units, tens)
// R6 - normal speed counts hours and minutes, display advancing once per minute
// R7 - fast speed counts minutes and seconds, display advancing once per second
// R8 - test speed advances the display at 60 counts per second; the code gives 50 counts per second on 50 Hz mains
// R9 - controller holds reset low while timing and high in its reset state
// R10 - while reset is high every timing and display counter is forced to zero
// R11 - controller raises pause on power failure, malfunction or cycle end
// R12 - while pause is high all counters stop and the display stays unchanged; the code keeps the done-pulse counters running
// R13 - main-time digit is compared for equality with the units counter
// R14 - two-digit total-time setting is compared with units and tens counters
// R15 - main and total done outputs are half-second positive pulses on equality
// R16 - total done also fires when elapsed time reaches 60, whatever the setting
// R17 - operator total-time setting should not exceed 60
// R18 - display counts the selected tick in modulo-60 then modulo-100 stages
// R19 - each display digit is BCD decoded into seven-segment drive
// R20 - on mains failure readouts go dark but display counts are kept
// R21 - colon blinks once per second from the 1 pps tick
// R22 - controller switches from main to topping phase on main done
// R23 - controller enters cycle end on total done, cleared only by reset
// R24 - each done pulse fires once per equality event, never repeated while paused
package etc_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int DONE_PULSE_MS = 500;
	localparam int DONE_CYC = CLK_HZ / 1000 * DONE_PULSE_MS;
	localparam logic [2:0] DIV_50HZ = 3'h5;
	localparam logic [2:0] DIV_60HZ = 3'h6;
	localparam logic [3:0] DIV_TEN = 4'h9;
	localparam logic [5:0] MOD60_LAST = 6'h3b;
	localparam logic [3:0] BCD_LAST = 4'h9;
	localparam logic [3:0] BCD_SIX = 4'h6;
	localparam logic [3:0] BCD_FIVE = 4'h5;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_DISPLAY = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_SPEED_LSB = 0;
	localparam int CTRL_STRAP_BIT = 2;
	localparam int CTRL_MAIN_LSB = 8;
	localparam int CTRL_TOTAL_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		ETC_SPEED_NORMAL,
		ETC_SPEED_FAST,
		ETC_SPEED_TEST
	} etc_speed_type;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} etc_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} etc_axi_resp_type;

	function automatic logic [6:0] etc_seg(input logic [3:0] d);
		case (d)
			4'h0: etc_seg = 7'h3f;
			4'h1: etc_seg = 7'h06;
			4'h2: etc_seg = 7'h5b;
			4'h3: etc_seg = 7'h4f;
			4'h4: etc_seg = 7'h66;
			4'h5: etc_seg = 7'h6d;
			4'h6: etc_seg = 7'h7d;
			4'h7: etc_seg = 7'h07;
			4'h8: etc_seg = 7'h7f;
			4'h9: etc_seg = 7'h6f;
			default: etc_seg = 7'h00;
		endcase
	endfunction : etc_seg
endpackage : etc_pkg

// >>> verilog/etc_elapsed_timer.sv
`timescale 1ns/1ps
module etc_elapsed_timer #(
	parameter int DONE_CYCLES = etc_pkg::DONE_CYC
) (
	// clock and bus reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire etc_pkg::etc_axi_req_type axi_req,
	output etc_pkg::etc_axi_resp_type axi_resp,
	// controller side
	input wire logic line_sync_pulse,
	input wire logic timer_reset,
	input wire logic pause_request,
	input wire logic mains_ok,
	output logic main_time_done,
	output logic total_time_done,
	// readouts, digit 0 is the rightmost
	output logic [3:0][6:0] segments,
	output logic colon
);
	import etc_pkg::*;

	logic [31:0] ctrl_r;
	etc_speed_type speed_select_switch;
	logic mains_freq_strap;
	logic [3:0] main_time_selector;
	logic [7:0] total_time_selector;
	logic run;
	logic line_prev_r;
	logic line_edge;
	logic [2:0] pre_r;
	logic [2:0] pre_last;
	logic [3:0] dec_r;
	logic half60_r;
	logic tick2;
	logic tick60;
	logic half_r;
	logic tick1;
	logic [5:0] sec_r;
	logic tick_min;
	logic sel_tick;
	logic [5:0] sub_r;
	logic [3:0] units_r;
	logic [3:0] tens_r;
	logic sub_wrap;
	logic [3:0] dmin_lo_r;
	logic [3:0] dmin_hi_r;
	logic [3:0] dhr_lo_r;
	logic [3:0] dhr_hi_r;
	logic [3:0][3:0] digit_w;
	logic main_match;
	logic total_match;
	logic main_prev_r;
	logic total_prev_r;
	logic main_event;
	logic total_event;
	logic [31:0] main_cnt_r;
	logic [31:0] total_cnt_r;
	logic main_done_r;
	logic total_done_r;
	logic [3:0][6:0] seg_r;
	logic colon_r;
	// bus state
	logic awready_r;
	logic wready_r;
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_fire;

	assign speed_select_switch = etc_speed_type'(ctrl_r[CTRL_SPEED_LSB +: 2]);
	assign mains_freq_strap = ctrl_r[CTRL_STRAP_BIT];
	assign main_time_selector = ctrl_r[CTRL_MAIN_LSB +: 4];
	assign total_time_selector = ctrl_r[CTRL_TOTAL_LSB +: 8];

	// R9 R12 timing and display counters run only while neither reset nor pause is high
	assign run = !timer_reset && !pause_request;
	// the pulse is 1-2 ms wide, so only its leading edge counts
	assign line_edge = line_sync_pulse && !line_prev_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_prev_r <= 1'b0;
		end else begin
			line_prev_r <= line_sync_pulse;
		end
	end

	// R2 strap picks the first division
	assign pre_last = mains_freq_strap ? (DIV_50HZ - 3'h1) : (DIV_60HZ - 3'h1);
	// R1 prescale then divide by ten gives 2 Hz
	assign tick2 = line_edge && run && (pre_r == pre_last) && (dec_r == DIV_TEN);
	// R3 every second line pulse gives the fast rate
	assign tick60 = line_edge && run && half60_r;
	// R4 1 pps on the falling half of the toggle, 1 ppm after modulo 60
	assign tick1 = tick2 && half_r;
	assign tick_min = tick1 && (sec_r == MOD60_LAST);

	always_ff @(posedge aclk) begin
		if (!aresetn || timer_reset) begin
			pre_r <= 3'h0;
			dec_r <= 4'h0;
			half60_r <= 1'b0;
		end else if (line_edge && !pause_request) begin
			half60_r <= !half60_r;
			if (pre_r >= pre_last) begin
				pre_r <= 3'h0;
				dec_r <= (dec_r == DIV_TEN) ? 4'h0 : dec_r + 4'h1;
			end else begin
				pre_r <= pre_r + 3'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || timer_reset) begin
			half_r <= 1'b0;
			sec_r <= 6'h00;
		end else begin
			if (tick2) begin
				half_r <= !half_r;
			end
			if (tick1) begin
				sec_r <= (sec_r == MOD60_LAST) ? 6'h00 : sec_r + 6'h01;
			end
		end
	end

	always_comb begin
		case (speed_select_switch)
			// R6 hours and minutes
			ETC_SPEED_NORMAL: sel_tick = tick_min;
			// R7 minutes and seconds
			ETC_SPEED_FAST: sel_tick = tick1;
			// R8 one count every second line pulse: sixty a second on 60 Hz mains, fifty on 50 Hz
			ETC_SPEED_TEST: sel_tick = tick60;
			default: sel_tick = tick_min;
		endcase
	end

	// R5 cascaded modulo 60, 10, 10 timing chain
	assign sub_wrap = sel_tick && (sub_r == MOD60_LAST);
	always_ff @(posedge aclk) begin
		// R10 reset zeroes the timing chain
		if (!aresetn || timer_reset) begin
			sub_r <= 6'h00;
			units_r <= 4'h0;
			tens_r <= 4'h0;
		end else if (sel_tick) begin
			sub_r <= (sub_r == MOD60_LAST) ? 6'h00 : sub_r + 6'h01;
			if (sub_wrap) begin
				units_r <= (units_r == BCD_LAST) ? 4'h0 : units_r + 4'h1;
				if (units_r == BCD_LAST) begin
					tens_r <= (tens_r == BCD_LAST) ? 4'h0 : tens_r + 4'h1;
				end
			end
		end
	end

	// R18 display: modulo 60 then modulo 100, in BCD
	// R20 these counts survive a mains failure; only the readouts blank
	always_ff @(posedge aclk) begin
		// R10 reset zeroes the display chain
		if (!aresetn || timer_reset) begin
			dmin_lo_r <= 4'h0;
			dmin_hi_r <= 4'h0;
			dhr_lo_r <= 4'h0;
			dhr_hi_r <= 4'h0;
		end else if (sel_tick) begin
			dmin_lo_r <= (dmin_lo_r == BCD_LAST) ? 4'h0 : dmin_lo_r + 4'h1;
			if (dmin_lo_r == BCD_LAST) begin
				dmin_hi_r <= (dmin_hi_r == BCD_FIVE) ? 4'h0 : dmin_hi_r + 4'h1;
				if (dmin_hi_r == BCD_FIVE) begin
					dhr_lo_r <= (dhr_lo_r == BCD_LAST) ? 4'h0 : dhr_lo_r + 4'h1;
					if (dhr_lo_r == BCD_LAST) begin
						dhr_hi_r <= (dhr_hi_r == BCD_LAST) ? 4'h0 : dhr_hi_r + 4'h1;
					end
				end
			end
		end
	end
	assign digit_w = {dhr_hi_r, dhr_lo_r, dmin_hi_r, dmin_lo_r};

	// R13 single-digit main compare
	assign main_match = (units_r == main_time_selector);
	// R14 two-digit total compare; R16 sixty always ends the cycle
	assign total_match = ({tens_r, units_r} == total_time_selector) || ((tens_r == BCD_SIX) && (units_r == 4'h0));
	// R24 only a fresh equality fires, so a frozen count cannot re-trigger
	assign main_event = main_match && !main_prev_r && !timer_reset;
	assign total_event = total_match && !total_prev_r && !timer_reset;

	always_ff @(posedge aclk) begin
		if (!aresetn || timer_reset) begin
			main_prev_r <= 1'b0;
			total_prev_r <= 1'b0;
		end else begin
			main_prev_r <= main_match;
			total_prev_r <= total_match;
		end
	end

	// R15 half-second done pulses
	always_ff @(posedge aclk) begin
		if (!aresetn || timer_reset) begin
			main_done_r <= 1'b0;
			main_cnt_r <= 32'h0000_0000;
		end else if (main_event) begin
			main_done_r <= 1'b1;
			main_cnt_r <= 32'(DONE_CYCLES - 1);
		end else if (main_cnt_r != 32'h0000_0000) begin
			main_cnt_r <= main_cnt_r - 32'h0000_0001;
		end else begin
			main_done_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || timer_reset) begin
			total_done_r <= 1'b0;
			total_cnt_r <= 32'h0000_0000;
		end else if (total_event) begin
			total_done_r <= 1'b1;
			total_cnt_r <= 32'(DONE_CYCLES - 1);
		end else if (total_cnt_r != 32'h0000_0000) begin
			total_cnt_r <= total_cnt_r - 32'h0000_0001;
		end else begin
			total_done_r <= 1'b0;
		end
	end

	// R19 one decoder per digit
	generate
		for (genvar i = 0; i < 4; i++) begin : g_digit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					seg_r[i] <= 7'h00;
				end else begin
					seg_r[i] <= mains_ok ? etc_seg(digit_w[i]) : 7'h00;
				end
			end
		end
	endgenerate

	// R21 colon follows the 1 pps square wave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			colon_r <= 1'b0;
		end else begin
			colon_r <= mains_ok && half_r;
		end
	end

	// register bus: address and data may arrive in either order
	assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (axi_req.awvalid && awready_r) begin
				awready_r <= 1'b0;
				aw_got_r <= 1'b1;
				awaddr_r <= axi_req.awaddr;
			end
			if (axi_req.wvalid && wready_r) begin
				wready_r <= 1'b0;
				w_got_r <= 1'b1;
				wdata_r <= axi_req.wdata;
				wstrb_r <= axi_req.wstrb;
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (awaddr_r[7:2] == ADDR_CTRL[7:2]) ? RESP_OKAY : RESP_DECERR;
			end
			if (bvalid_r && axi_req.bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	generate
		for (genvar b = 0; b < 4; b++) begin : g_lane
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ctrl_r[8*b +: 8] <= CTRL_RESET[8*b +: 8];
				end else if (wr_fire && wstrb_r[b] && (awaddr_r[7:2] == ADDR_CTRL[7:2])) begin
					ctrl_r[8*b +: 8] <= wdata_r[8*b +: 8];
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else if (axi_req.arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= RESP_OKAY;
			case (axi_req.araddr[7:2])
				ADDR_CTRL[7:2]: rdata_r <= ctrl_r;
				ADDR_TIMING[7:2]: rdata_r <= {14'h0000, total_done_r, main_done_r, tens_r, units_r, 2'h0, sub_r};
				ADDR_DISPLAY[7:2]: rdata_r <= {15'h0000, half_r, dhr_hi_r, dhr_lo_r, dmin_hi_r, dmin_lo_r};
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= RESP_DECERR;
				end
			endcase
		end else if (rvalid_r && axi_req.rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign axi_resp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r, bresp: bresp_r,
		arready: arready_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};
	assign main_time_done = main_done_r;
	assign total_time_done = total_done_r;
	assign segments = seg_r;
	assign colon = colon_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_main_fire;
		main_event ##1 main_time_done;
	endsequence
	sequence s_total_fire;
		total_event ##1 total_time_done;
	endsequence

	a_reset_clears_all: assert property (timer_reset |=> (units_r == 4'h0 && tens_r == 4'h0 && digit_w == '0)) // R10
		else $error("counters not cleared by reset");
	a_pause_freezes_display: assert property (pause_request |=> $stable(digit_w) && $stable(units_r)) // R12
		else $error("display moved while paused");
	a_prescale_range: assert property (pre_r <= DIV_60HZ - 3'h1) // R2
		else $error("prescaler out of range");
	a_units_bcd: assert property (units_r <= BCD_LAST && tens_r <= BCD_LAST && sub_r <= MOD60_LAST) // R5
		else $error("timing chain digit out of range");
	a_main_done_follows: assert property (main_event |-> s_main_fire) // R13
		else $error("main done missed its match");
	a_total_done_follows: assert property (total_event |-> s_total_fire) // R14
		else $error("total done missed its match");
	a_sixty_ends_cycle: assert property ((tens_r == BCD_SIX && units_r == 4'h0 && !total_prev_r && !timer_reset)
		|=> total_time_done) // R16
		else $error("sixty did not raise total done");
	a_done_only_on_event: assert property ($rose(main_time_done) |-> $past(main_event)) // R24
		else $error("main done without a new match");
	a_done_width: assert property ($rose(total_time_done) |-> total_time_done[*8]) // R15
		else $error("total done pulse too short");
	a_fast_rate: assert property ((speed_select_switch == ETC_SPEED_FAST && sel_tick) |-> tick1) // R7
		else $error("fast speed not on the seconds tick");
	a_colon_from_pps: assert property (($changed(half_r) && !$past(timer_reset)) |-> $past(tick2)) // R21
		else $error("colon toggled off the 2 Hz tick");
endmodule : etc_elapsed_timer

// >>> verification/etc_ctrl_model.sv
`timescale 1ns/1ps
module etc_ctrl_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// operator and supply
	input wire logic start,
	input wire logic fault,
	input wire logic mains_ok,
	// timer side
	input wire logic main_time_done,
	input wire logic total_time_done,
	output logic timer_reset,
	output logic pause_request,
	output logic topping_r,
	output logic cycle_end_r
);
	logic running_r;

	always_ff @(posedge aclk) begin
		running_r <= aresetn & start;
	end

	assign timer_reset = !running_r;

	// pause on fault, outage or end
	assign pause_request = running_r & (fault | !mains_ok | cycle_end_r);

	always_ff @(posedge aclk) begin
		if (!running_r)
			topping_r <= 1'h0;
		else if (main_time_done)
			topping_r <= 1'h1;
	end

	always_ff @(posedge aclk) begin
		if (!running_r)
			cycle_end_r <= 1'h0;
		else if (total_time_done)
			cycle_end_r <= 1'h1;
	end
endmodule : etc_ctrl_model

// >>> verification/elapsed_time_counter_tb.sv
`timescale 1ns/1ps
module elapsed_time_counter_tb;
	import etc_pkg::*;
	logic aclk;
	logic aresetn;
	etc_axi_req_type axi_req;
	etc_axi_resp_type axi_resp;
	logic line_sync_pulse, start, fault, mains_ok, timer_reset, pause_request;
	logic topping_r, cycle_end_r, main_time_done, total_time_done, colon, md_q, td_q;
	logic [3:0][6:0] segments;
	logic [31:0] rd;
	logic [1:0] rs;
	int errors, tests_run, main_rises, total_rises, md_w, td_w, m, k, n, ppc, mr0, tr0;

	etc_elapsed_timer #(.DONE_CYCLES(16)) etc_elapsed_timer_i (.aclk(aclk), .aresetn(aresetn),
		.axi_req(axi_req), .axi_resp(axi_resp), .line_sync_pulse(line_sync_pulse),
		.timer_reset(timer_reset), .pause_request(pause_request), .mains_ok(mains_ok),
		.main_time_done(main_time_done), .total_time_done(total_time_done),
		.segments(segments), .colon(colon));

	etc_ctrl_model etc_ctrl_model_i (.aclk(aclk), .aresetn(aresetn), .start(start), .fault(fault),
		.mains_ok(mains_ok), .main_time_done(main_time_done), .total_time_done(total_time_done),
		.timer_reset(timer_reset), .pause_request(pause_request), .topping_r(topping_r),
		.cycle_end_r(cycle_end_r));

	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic stall(input int c);
		if (c >= 200) begin
			errors++;
			$display("FAIL bus answer expected within 200 seen none");
			results();
		end
	endtask : stall

	// bready and rready stay high, so only the request channels move here
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int c;
		c = 0;
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.awvalid <= 1'h1;
		axi_req.wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			c++;
			if (axi_resp.awready)
				axi_req.awvalid <= 1'h0;
			if (axi_resp.wready)
				axi_req.wvalid <= 1'h0;
		end while (axi_resp.bvalid !== 1'h1 && c < 200);
		rs = axi_resp.bresp;
		stall(c);
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		int c;
		c = 0;
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			c++;
			if (axi_resp.arready)
				axi_req.arvalid <= 1'h0;
		end while (axi_resp.rvalid !== 1'h1 && c < 200);
		rd = axi_resp.rdata;
		rs = axi_resp.rresp;
		stall(c);
	endtask : rd_reg

	// tail leaves room for input sync, counter and done register
	task automatic pulses(input int cnt);
		repeat (cnt) begin
			@(posedge aclk);
			line_sync_pulse <= 1'h1;
			@(posedge aclk);
			line_sync_pulse <= 1'h0;
		end
		repeat (8) @(posedge aclk);
	endtask : pulses

	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction : bcd

	function automatic logic [15:0] disp(input int c);
		return {bcd(c / 60 % 100), bcd(c % 60)};
	endfunction : disp

	function automatic logic [31:0] cfg(input int sp, input int st, input int mn, input logic [7:0] tot);
		return {8'h00, tot, 4'h0, 4'(mn), 5'h00, 1'(st), 2'(sp)};
	endfunction : cfg

	task automatic disp_chk(input int c);
		rd_reg(ADDR_DISPLAY);
		chk("display", {16'h0000, rd[15:0]}, {16'h0000, disp(c)});
	endtask : disp_chk

	always @(posedge aclk) begin
		md_q <= main_time_done;
		td_q <= total_time_done;
		md_w <= main_time_done ? md_w + 1 : 0;
		td_w <= total_time_done ? td_w + 1 : 0;
		if (main_time_done === 1'h1 && md_q === 1'h0)
			main_rises++;
		if (total_time_done === 1'h1 && td_q === 1'h0)
			total_rises++;
		if (md_q === 1'h1 && main_time_done === 1'h0)
			chk("main done width", md_w, 16);
		if (td_q === 1'h1 && total_time_done === 1'h0)
			chk("total done width", td_w, 16);
	end

	initial begin
		axi_req = '0;
		axi_req.bready = 1'h1;
		axi_req.rready = 1'h1;
		aresetn = 1'h0;
		line_sync_pulse = 1'h0;
		start = 1'h0;
		fault = 1'h0;
		mains_ok = 1'h1;
		void'($urandom(79860));
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		rd_reg(ADDR_CTRL);
		chk("ctrl reset", rd, CTRL_RESET);
		rd_reg(8'h0c);
		chk("unmapped resp", 32'(rs), 32'(RESP_DECERR));
		wr(ADDR_TIMING, 32'hffff_ffff);
		chk("read-only resp", 32'(rs), 32'(RESP_DECERR));
		rd_reg(ADDR_TIMING);
		chk("timing cleared", rd, 32'h0000_0000);
		chk("digits zero", 32'(segments), 32'({4{7'h3f}}));
		chk("colon off", 32'(colon), 32'h0000_0000);
		for (int sp = 0; sp < 3; sp++) begin
			// first pass draws the strap, later passes flip it so both mains rates are run
			n = (sp == 0) ? int'($urandom % 2) : 1 - n;
			ppc = (sp == 2) ? 2 : (sp == 1) ? 20 * (6 - n) : 1200 * (6 - n);
			wr(ADDR_CTRL, cfg(sp, n, 9, 8'h60));
			rd_reg(ADDR_CTRL);
			chk("ctrl readback", rd, cfg(sp, n, 9, 8'h60));
			start <= 1'h1;
			pulses(2 * ppc - 1);
			disp_chk(1);
			pulses(1);
			disp_chk(2);
			if (sp == 1) begin
				pulses(ppc / 2);
				chk("colon", 32'(colon), 32'h0000_0001);
			end
			start <= 1'h0;
			repeat (3) @(posedge aclk);
			disp_chk(0);
		end
		m = 1 + $urandom % 8;
		k = 2 * (1 + $urandom % 50);
		wr(ADDR_CTRL, cfg(2, 0, m, 8'(m + 1)));
		mr0 = main_rises;
		tr0 = total_rises;
		start <= 1'h1;
		pulses(k);
		disp_chk(k / 2);
		fault <= 1'h1;
		pulses(40);
		disp_chk(k / 2);
		fault <= 1'h0;
		pulses(120 * m - k);
		chk("main done", main_rises - mr0, 1);
		chk("topping", 32'(topping_r), 32'h0000_0001);
		chk("total early", total_rises - tr0, 0);
		pulses(120);
		chk("total done", total_rises - tr0, 1);
		chk("cycle end", 32'(cycle_end_r), 32'h0000_0001);
		pulses(240);
		chk("main once", main_rises - mr0, 1);
		chk("total once", total_rises - tr0, 1);
		disp_chk(60 * (m + 1));
		mains_ok <= 1'h0;
		repeat (3) @(posedge aclk);
		chk("dark digits", 32'(segments), 32'h0000_0000);
		disp_chk(60 * (m + 1));
		mains_ok <= 1'h1;
		repeat (3) @(posedge aclk);
		chk("minute digits", 32'(segments[1:0]), 32'({2{7'h3f}}));
		start <= 1'h0;
		// deliberately above sixty so only the fixed sixty decode can end the cycle
		wr(ADDR_CTRL, cfg(2, 0, 7, 8'h70));
		chk("cycle end cleared", 32'(cycle_end_r), 32'h0000_0000);
		mr0 = main_rises;
		tr0 = total_rises;
		start <= 1'h1;
		pulses(7199);
		chk("sixty early", total_rises - tr0, 0);
		chk("main repeats", main_rises - mr0, 6);
		pulses(1);
		chk("sixty", total_rises - tr0, 1);
		results();
	end
endmodule : elapsed_time_counter_tb
